// ===== bench/cps_top_assertions.sv
`timescale 1ns/1ps
module cps_top_assertions (
    input wire clock, // system clock
    input wire rst, // sync reset
    input wire avs_read, // read request
    input wire avs_write, // write request
    input wire avs_waitrequest, // stall
    input wire pb_tick, // playback sample slot
    input wire [1:0] rec_filter_type, // decimation type
    input wire [2:0] rec_biquads, // active biquads
    input wire [4:0] rec_fir_taps, // fir length
    input wire rec_iir_on, // iir active
    input wire rec_left_on, // left channel processed
    input wire [7:0] rec_osr, // record oversampling
    input wire [1:0] pb_interp_type, // interpolation type
    input wire [10:0] pb_osr, // playback oversampling
    input wire pb_sample_valid // sample strobe
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // sequences
    // ----------------------------------------
    sequence s_stall_go;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    sequence s_tick_seen;
        $past(pb_tick, 2);
    endsequence
    bus_answer_a: assert property ($rose(avs_read || avs_write) |-> s_stall_go)
        else $error("bus answer not in two cycles");
    iir_present_a: assert property (rec_iir_on) else $error("record iir off");
    bq_fir_excl_a: assert property (!(rec_biquads != 3'h0 && rec_fir_taps != 5'h00))
        else $error("biquads and fir together");
    fir_length_a: assert property (rec_fir_taps != 5'h00 |->
        rec_fir_taps == ((rec_filter_type == 2'h1) ? 5'h14 : 5'h19)) else $error("fir length wrong");
    bq_count_a: assert property (rec_biquads != 3'h0 |->
        rec_biquads == ((rec_filter_type == 2'h1) ? 3'h3 : 3'h5)) else $error("biquad count wrong");
    rec_osr_legal_a: assert property (rec_osr == 8'h80 || rec_osr == 8'h40 || rec_osr == 8'h20)
        else $error("record osr illegal");
    pb_osr_range_a: assert property (pb_osr >= 11'h001 && pb_osr <= 11'h400)
        else $error("playback osr out of range");
    interp_type_a: assert property (pb_interp_type != 2'h3) else $error("bad interp type");
    chain_frozen_a: assert property (rec_left_on && $past(rec_left_on) |->
        $stable({rec_filter_type, rec_biquads, rec_fir_taps, rec_osr})) else $error("chain moved powered");
    sample_latency_a: assert property (pb_sample_valid |-> s_tick_seen)
        else $error("sample without tick");
endmodule
bind cps_top cps_top_assertions chk (.clock(clock), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .pb_tick(pb_tick), .rec_filter_type(rec_filter_type),
    .rec_biquads(rec_biquads), .rec_fir_taps(rec_fir_taps), .rec_iir_on(rec_iir_on), .rec_left_on(rec_left_on),
    .rec_osr(rec_osr), .pb_interp_type(pb_interp_type), .pb_osr(pb_osr), .pb_sample_valid(pb_sample_valid));

// ===== bench/tb_codec_processing_block_select.sv
`timescale 1ns/1ps
`include "cps_map.vh"
module tb_codec_processing_block_select;
    logic clock, rst, avs_read, avs_write, pb_tick;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, q, seed, w;
    logic [3:0] avs_byteenable;
    logic [1:0] rsp;
    logic [15:0] pb_q[$];
    wire [31:0] avs_readdata;
    wire avs_waitrequest, rec_iir_on, rec_left_on, pb_sample_valid;
    wire [1:0] avs_response, rec_filter_type, pb_interp_type;
    wire [2:0] rec_biquads;
    wire [4:0] rec_fir_taps;
    wire [7:0] rec_osr;
    wire [10:0] pb_osr;
    wire [15:0] pb_sample;
    int err_total, cmp_count, i, t, s;
    cps_top dut (.clock(clock), .rst(rst), .ce(1'b1), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .pb_tick(pb_tick), .rec_filter_type(rec_filter_type), .rec_biquads(rec_biquads),
        .rec_fir_taps(rec_fir_taps), .rec_iir_on(rec_iir_on), .rec_left_on(rec_left_on), .rec_osr(rec_osr),
        .pb_interp_type(pb_interp_type), .pb_osr(pb_osr), .pb_sample(pb_sample), .pb_sample_valid(pb_sample_valid));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    function logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task finish_test;
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // bus master: holds the request until waitrequest is seen low
    // ----------------------------------------
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            err_total++;
            $display("MISMATCH at %0t: bus hang", $time);
        end
        q = avs_readdata;
        rsp = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(negedge clock);
    endtask
    // refused writes keep the old value and raise the error flag
    task cfg(input logic [7:0] a, input logic [31:0] v, input logic [31:0] old, input bit ok, input logic [31:0] m);
        bus(1'b1, `CPS_REG_STATUS, 32'h2);
        bus(1'b1, a, v);
        bus(1'b0, a, 32'h0);
        check(q & m, (ok ? v : old) & m);
        bus(1'b0, `CPS_REG_STATUS, 32'h0);
        check(q[1], !ok);
    endtask
    task tick;
        @(posedge clock);
        pb_tick <= 1'b1;
        @(posedge clock);
        pb_tick <= 1'b0;
        @(posedge clock);
        @(negedge clock);
    endtask
    initial begin
        repeat (40000) @(posedge clock);
        err_total++;
        finish_test();
    end
    initial begin
        {rst, avs_read, avs_write, pb_tick, avs_address, avs_writedata} = {1'b1, 43'h0};
        avs_byteenable = 4'hF;
        seed = 32'hD67F;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        check({rec_filter_type, rec_biquads, rec_fir_taps, rec_iir_on}, 11'h001);
        check({rec_osr, pb_osr}, {8'h80, 11'h080});
        bus(1'b0, 8'hFC, 32'h0);
        check(rsp, 2'b10);
        for (i = 1; i <= 18; i++) begin
            t = (i - 1) / 6;
            s = (i - 1) % 3;
            bus(1'b1, `CPS_REG_REC_CHAIN, i);
            check(rec_filter_type, t);
            check(rec_biquads, (s == 1) ? ((t == 1) ? 3 : 5) : 0);
            check(rec_fir_taps, (s == 2) ? ((t == 1) ? 20 : 25) : 0);
            check(rec_iir_on, 1);
            bus(1'b0, `CPS_REG_STATUS, 32'h0);
            check(q[2], t == 0);
            bus(1'b1, `CPS_REG_CTRL, 32'h1);
            check(rec_left_on, ((i - 1) % 6) < 3);
            bus(1'b1, `CPS_REG_CTRL, 32'h0);
        end
        bus(1'b1, `CPS_REG_CTRL, 32'h1);
        cfg(`CPS_REG_REC_CHAIN, 32'h5, 32'h12, 0, 32'h1F);
        check({rec_biquads, rec_fir_taps}, {3'h0, 5'h19});
        bus(1'b1, `CPS_REG_CTRL, 32'h0);
        for (i = 1; i <= 25; i++) begin
            bus(1'b1, `CPS_REG_PB_CHAIN, i);
            check(pb_interp_type, (i <= 6 || i >= 23) ? 0 : ((i <= 16) ? 1 : 2));
        end
        cfg(`CPS_REG_PB_CHAIN, 32'h1A, 32'h19, 0, 32'h1F);
        cfg(`CPS_REG_PB_CHAIN, 32'h0, 32'h19, 0, 32'h1F);
        cfg(`CPS_REG_REC_OSR, 32'h40, 32'h80, 1, 32'hFF);
        cfg(`CPS_REG_REC_OSR, 32'h64, 32'h40, 0, 32'hFF);
        cfg(`CPS_REG_REC_OSR, 32'h20, 32'h40, 1, 32'hFF);
        check(rec_osr, 8'h20);
        cfg(`CPS_REG_PB_OSR, 32'h1, 32'h80, 1, 32'h7FF);
        cfg(`CPS_REG_PB_OSR, 32'h401, 32'h1, 0, 32'h7FF);
        cfg(`CPS_REG_PB_OSR, 32'h0, 32'h1, 0, 32'h7FF);
        cfg(`CPS_REG_PB_OSR, 32'h400, 32'h1, 1, 32'h7FF);
        check(pb_osr, 11'h400);
        cfg(`CPS_REG_PB_VOL, 32'h81, 32'h0, 1, 32'hFF);
        cfg(`CPS_REG_PB_VOL, 32'h80, 32'h81, 0, 32'hFF);
        cfg(`CPS_REG_PB_VOL, 32'h31, 32'h81, 0, 32'hFF);
        cfg(`CPS_REG_PB_VOL, 32'h30, 32'h81, 1, 32'hFF);
        cfg(`CPS_REG_PB_VOL, 32'h0, 32'h30, 1, 32'hFF);
        cfg(`CPS_REG_PB_RATE, 32'h8, 32'h0, 1, 32'hFF);
        cfg(`CPS_REG_PB_RATE, 32'h7, 32'h8, 0, 32'hFF);
        cfg(`CPS_REG_PB_RATE, 32'hC1, 32'h8, 0, 32'hFF);
        cfg(`CPS_REG_PB_RATE, 32'hC0, 32'h8, 1, 32'hFF);
        @(posedge clock);
        avs_byteenable <= 4'h1;
        cfg(`CPS_REG_PB_RATE, 32'h1230, 32'hC0, 1, 32'hFF);
        avs_byteenable <= 4'hF;
        // coefficient port: writes step the address, reads do not
        w = seed;
        seed = lfsr(seed);
        bus(1'b1, `CPS_REG_COEF_ADDR, 32'h3);
        bus(1'b1, `CPS_REG_COEF_DATA, w);
        bus(1'b1, `CPS_REG_COEF_DATA, seed);
        bus(1'b1, `CPS_REG_COEF_ADDR, 32'h3);
        bus(1'b0, `CPS_REG_COEF_DATA, 32'h0);
        check(q[23:0], w[23:0]);
        bus(1'b1, `CPS_REG_COEF_ADDR, 32'h4);
        bus(1'b0, `CPS_REG_COEF_DATA, 32'h0);
        check(q[23:0], seed[23:0]);
        // fill past full while no tick drains, then drain past empty under mute
        bus(1'b1, `CPS_REG_CTRL, 32'h6);
        for (i = 0; i < 17; i++) begin
            seed = lfsr(seed);
            if (pb_q.size() < 16) pb_q.push_back(seed[15:0]);
            bus(1'b1, `CPS_REG_PB_DATA, seed);
        end
        bus(1'b0, `CPS_REG_STATUS, 32'h0);
        check(q[5:4], 2'b01);
        for (i = 0; i < 17; i++) begin
            tick();
            check(pb_sample_valid, pb_q.size() > 0);
            if (pb_q.size() > 0) begin
                check(pb_sample, 16'h0);
                void'(pb_q.pop_front());
            end
        end
        bus(1'b0, `CPS_REG_STATUS, 32'h0);
        check(q[5:4], 2'b10);
        bus(1'b1, `CPS_REG_CTRL, 32'h2);
        seed = lfsr(seed);
        bus(1'b1, `CPS_REG_PB_DATA, seed);
        tick();
        check(pb_sample, seed[15:0]);
        bus(1'b1, `CPS_REG_CTRL, 32'hA);
        tick();
        check(pb_sample_valid, 1);
        bus(1'b1, `CPS_REG_CTRL, 32'h0);
        finish_test();
    end
endmodule

// ===== core/cps_coef_mem.v
`timescale 1ns/1ps
module cps_coef_mem #(
    parameter WIDTH = 24,
    parameter DEPTH = 64,
    parameter AW = 6
) (
    input wire clock, // system clock
    input wire ce, // clock enable
    input wire we, // write strobe
    input wire [AW-1:0] waddr, // write address
    input wire [WIDTH-1:0] wdata, // write data
    input wire [AW-1:0] raddr, // read address
    output reg [WIDTH-1:0] rdata // registered read data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    // no fixed values: every word is software writable
    always @(posedge clock) begin
        if (ce) begin
            if (we)
                mem[waddr] <= wdata;
            rdata <= mem[raddr];
        end
    end
endmodule

// ===== core/cps_fifo.v
`timescale 1ns/1ps
module cps_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clock, // system clock
    input wire rst, // sync reset
    input wire ce, // clock enable
    input wire in_valid, // write request
    output wire in_ready, // not full
    input wire [WIDTH-1:0] in_data, // write data
    output wire out_valid, // not empty
    input wire out_ready, // read accept
    output reg [WIDTH-1:0] out_data // head word
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_reg;
    reg [AW-1:0] rd_reg;
    reg [AW:0] cnt_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_reg != DEPTH[AW:0]);
    assign out_valid = (cnt_reg != {(AW+1){1'b0}});
    always @* begin
        out_data = mem[rd_reg];
    end
    always @(posedge clock) begin
        if (rst) begin
            wr_reg <= {AW{1'b0}};
            rd_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else if (ce) begin
            if (push) begin
                mem[wr_reg] <= in_data;
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop)
                rd_reg <= rd_reg + 1'b1;
            if (push && !pop)
                cnt_reg <= cnt_reg + 1'b1;
            else if (pop && !push)
                cnt_reg <= cnt_reg - 1'b1;
        end
    end
endmodule

// ===== core/cps_map.vh
`ifndef CPS_MAP_VH
`define CPS_MAP_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CPS_REG_CTRL 8'h00
`define CPS_REG_REC_CHAIN 8'h04
`define CPS_REG_REC_OSR 8'h08
`define CPS_REG_PB_CHAIN 8'h0C
`define CPS_REG_PB_OSR 8'h10
`define CPS_REG_PB_VOL 8'h14
`define CPS_REG_COEF_ADDR 8'h18
`define CPS_REG_COEF_DATA 8'h1C
`define CPS_REG_STATUS 8'h20
`define CPS_REG_PB_DATA 8'h24
`define CPS_REG_PB_RATE 8'h28
// ----------------------------------------
// control field positions
// ----------------------------------------
`define CPS_CTRL_REC_PWR 0
`define CPS_CTRL_PB_PWR 1
`define CPS_CTRL_MUTE 2
`define CPS_CTRL_BEEP 3
`define CPS_CTRL_AUTOMUTE 4
// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define CPS_REC_CHAIN_RST 5'h01
`define CPS_REC_OSR_RST 8'h80
`define CPS_PB_CHAIN_RST 5'h01
`define CPS_PB_OSR_RST 11'h080
`define CPS_PB_OSR_MAX 11'h400
`define CPS_PB_VOL_RST 8'h00
`define CPS_PB_VOL_MAX 8'h30
`define CPS_PB_VOL_MIN 8'h81
`define CPS_PB_RATE_MIN 8'h08
`define CPS_PB_RATE_MAX 8'hC0
`define CPS_PB_RATE_RST 8'h30
`define CPS_AUTOMUTE_RUN 12'h800
`define CPS_COEF_WORDS 64
`define CPS_FIFO_DEPTH 16
`endif

// ===== core/cps_top.v
// Summary of operation
// - reset record chain is stereo, filter A, first-order IIR, no biquads or FIR
// - any record chain accepts oversampling 128, 64 or 32; status bit 2 is set for filter A at 128 or 64, B at 64, C at 32
// - every record chain has IIR; biquads, FIR or neither, never both; mono is right
// - playback accepts sample rates from 8 kHz to 192 kHz
// - playback order: processing engine, interpolation filter, delta-sigma modulator
// - playback oversampling ratio programmable from 1 to 1024
// - three interpolation filter types, chosen by the playback chain
// - playback digital volume spans -63.5 dB to +24 dB
// - playback IIR and biquad coefficients fully software writable
// - playback has sawtooth (phase accumulator) tone generator and automatic digital mute
`timescale 1ns/1ps
`include "cps_map.vh"
module cps_top (
    input wire clock, // 250 MHz system clock
    input wire rst, // sync reset, active high
    input wire ce, // clock enable, freezes all state
    input wire [7:0] avs_address, // byte address
    input wire avs_read, // read request
    input wire avs_write, // write request
    input wire [31:0] avs_writedata, // write data
    input wire [3:0] avs_byteenable, // byte lanes
    output reg [31:0] avs_readdata, // read data
    output wire avs_waitrequest, // stall
    output reg [1:0] avs_response, // 00 ok, 10 slave error
    input wire pb_tick, // playback sample strobe, same clock
    output wire [1:0] rec_filter_type, // 0 A, 1 B, 2 C
    output wire [2:0] rec_biquads, // active biquads
    output wire [4:0] rec_fir_taps, // FIR length, 0 if none
    output wire rec_iir_on, // first-order IIR active
    output wire rec_left_on, // left channel processed
    output wire [7:0] rec_osr, // record oversampling ratio
    output wire [1:0] pb_interp_type, // 0 A, 1 B, 2 C
    output wire [10:0] pb_osr, // playback oversampling ratio
    output reg [15:0] pb_sample, // sample to modulator
    output reg pb_sample_valid // one-cycle pulse
);
    // ----------------------------------------
    // register state
    // ----------------------------------------
    reg [4:0] ctrl_reg;
    reg [4:0] rec_chain_reg;
    reg [7:0] rec_osr_reg;
    reg [4:0] pb_chain_reg;
    reg [10:0] pb_osr_reg;
    reg [7:0] pb_vol_reg;
    reg [5:0] coef_addr_reg;
    reg [7:0] pb_rate_reg;
    reg cfg_err_reg;
    reg [1:0] bus_state_reg;
    reg [15:0] tone_reg;
    reg [11:0] quiet_cnt_reg;
    reg auto_muted_reg;
    reg [15:0] eng_reg;
    reg eng_valid_reg;
    localparam BS_IDLE = 2'b01;
    localparam BS_DONE = 2'b10;
    wire rec_pwr = ctrl_reg[`CPS_CTRL_REC_PWR];
    wire pb_pwr = ctrl_reg[`CPS_CTRL_PB_PWR];
    wire req = (avs_read || avs_write) && bus_state_reg == BS_IDLE;
    // a write lands at the edge where the master sees waitrequest low
    wire wr = avs_write && bus_state_reg == BS_DONE;
    wire [31:0] wd = avs_writedata & {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    // answer one cycle after the request is taken
    assign avs_waitrequest = (avs_read || avs_write) && bus_state_reg != BS_DONE;
    // ----------------------------------------
    // record chain decode
    // ----------------------------------------
    reg [1:0] rc_type;
    reg [2:0] rc_bq;
    reg [4:0] rc_fir;
    reg rc_stereo;
    reg rc_osr_ok;
    always @* begin
        rc_type = 2'h0;
        rc_bq = 3'h0;
        rc_fir = 5'h00;
        rc_stereo = 1'b1;
        rc_osr_ok = 1'b0;
        if (rec_chain_reg >= 5'h01 && rec_chain_reg <= 5'h12) begin
            rc_type = (rec_chain_reg <= 5'h06) ? 2'h0 : (rec_chain_reg <= 5'h0C) ? 2'h1 : 2'h2;
            rc_stereo = (((rec_chain_reg - 5'h01) % 5'h06) < 5'h03);
            case ((rec_chain_reg - 5'h01) % 5'h03)
                5'h01: rc_bq = (rc_type == 2'h1) ? 3'h3 : 3'h5;
                5'h02: rc_fir = (rc_type == 2'h1) ? 5'h14 : 5'h19;
                default: rc_bq = 3'h0;
            endcase
        end
        case (rc_type)
            2'h0: rc_osr_ok = (rec_osr_reg == 8'h80) || (rec_osr_reg == 8'h40);
            2'h1: rc_osr_ok = (rec_osr_reg == 8'h40);
            default: rc_osr_ok = (rec_osr_reg == 8'h20);
        endcase
    end
    assign rec_filter_type = rc_type;
    assign rec_biquads = rc_bq;
    assign rec_fir_taps = rc_fir;
    assign rec_iir_on = 1'b1;
    assign rec_left_on = rc_stereo && rec_pwr;
    assign rec_osr = rec_osr_reg;
    // ----------------------------------------
    // playback chain decode
    // ----------------------------------------
    reg [1:0] pc_type;
    always @* begin
        if (pb_chain_reg <= 5'h06 || pb_chain_reg >= 5'h17)
            pc_type = 2'h0;
        else if (pb_chain_reg <= 5'h10)
            pc_type = 2'h1;
        else
            pc_type = 2'h2;
    end
    assign pb_interp_type = pc_type;
    assign pb_osr = pb_osr_reg;
    // ----------------------------------------
    // coefficient memory and sample fifo
    // ----------------------------------------
    wire coef_we = wr && avs_address == `CPS_REG_COEF_DATA;
    wire [23:0] coef_rd;
    cps_coef_mem #(.WIDTH(24), .DEPTH(`CPS_COEF_WORDS), .AW(6)) u_coef (
        .clock(clock),
        .ce(ce),
        .we(coef_we),
        .waddr(coef_addr_reg),
        .wdata(wd[23:0]),
        .raddr(coef_addr_reg),
        .rdata(coef_rd)
    );
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [15:0] fifo_out_data;
    wire pb_push = wr && avs_address == `CPS_REG_PB_DATA && fifo_in_ready;
    wire pb_pop = pb_tick && pb_pwr && fifo_out_valid;
    cps_fifo #(.WIDTH(16), .DEPTH(`CPS_FIFO_DEPTH), .AW(4)) u_fifo (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .in_valid(pb_push),
        .in_ready(fifo_in_ready),
        .in_data(wd[15:0]),
        .out_valid(fifo_out_valid),
        .out_ready(pb_pop),
        .out_data(fifo_out_data)
    );
    // ----------------------------------------
    // register writes and bus answer
    // ----------------------------------------
    wire known = avs_address <= `CPS_REG_PB_RATE && avs_address[1:0] == 2'b00;
    always @(posedge clock) begin
        if (rst) begin
            ctrl_reg <= 5'h00;
            rec_chain_reg <= `CPS_REC_CHAIN_RST;
            rec_osr_reg <= `CPS_REC_OSR_RST;
            pb_chain_reg <= `CPS_PB_CHAIN_RST;
            pb_osr_reg <= `CPS_PB_OSR_RST;
            pb_vol_reg <= `CPS_PB_VOL_RST;
            coef_addr_reg <= 6'h00;
            pb_rate_reg <= `CPS_PB_RATE_RST;
            cfg_err_reg <= 1'b0;
            bus_state_reg <= BS_IDLE;
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'b00;
        end else if (ce) begin
            case (bus_state_reg)
                BS_IDLE: begin
                    if (req) begin
                        bus_state_reg <= BS_DONE;
                        avs_response <= known ? 2'b00 : 2'b10;
                        avs_readdata <= 32'h0000_0000;
                        if (avs_read) begin
                            case (avs_address)
                                `CPS_REG_CTRL: avs_readdata <= {27'h0, ctrl_reg};
                                `CPS_REG_REC_CHAIN: avs_readdata <= {27'h0, rec_chain_reg};
                                `CPS_REG_REC_OSR: avs_readdata <= {24'h0, rec_osr_reg};
                                `CPS_REG_PB_CHAIN: avs_readdata <= {27'h0, pb_chain_reg};
                                `CPS_REG_PB_OSR: avs_readdata <= {21'h0, pb_osr_reg};
                                `CPS_REG_PB_VOL: avs_readdata <= {24'h0, pb_vol_reg};
                                `CPS_REG_COEF_ADDR: avs_readdata <= {26'h0, coef_addr_reg};
                                `CPS_REG_COEF_DATA: avs_readdata <= {8'h0, coef_rd};
                                `CPS_REG_STATUS: avs_readdata <= {26'h0, fifo_in_ready, fifo_out_valid,
                                                                  auto_muted_reg, rc_osr_ok, cfg_err_reg,
                                                                  pb_pwr};
                                `CPS_REG_PB_RATE: avs_readdata <= {24'h0, pb_rate_reg};
                                default: avs_readdata <= 32'h0000_0000;
                            endcase
                        end
                    end
                end
                BS_DONE: bus_state_reg <= BS_IDLE;
                default: bus_state_reg <= BS_IDLE;
            endcase
            if (wr) begin
                case (avs_address)
                    `CPS_REG_CTRL: ctrl_reg <= wd[4:0];
                    `CPS_REG_REC_CHAIN: begin
                        // changing a live chain would feed samples to a half-built filter
                        if (!rec_pwr && wd[4:0] >= 5'h01 && wd[4:0] <= 5'h12)
                            rec_chain_reg <= wd[4:0];
                        else
                            cfg_err_reg <= 1'b1;
                    end
                    `CPS_REG_REC_OSR: begin
                        if (!rec_pwr && (wd[7:0] == 8'h80 || wd[7:0] == 8'h40 || wd[7:0] == 8'h20))
                            rec_osr_reg <= wd[7:0];
                        else
                            cfg_err_reg <= 1'b1;
                    end
                    `CPS_REG_PB_CHAIN: begin
                        if (!pb_pwr && wd[4:0] >= 5'h01 && wd[4:0] <= 5'h19)
                            pb_chain_reg <= wd[4:0];
                        else
                            cfg_err_reg <= 1'b1;
                    end
                    `CPS_REG_PB_OSR: begin
                        if (!pb_pwr && wd[10:0] >= 11'h001 && wd[10:0] <= `CPS_PB_OSR_MAX)
                            pb_osr_reg <= wd[10:0];
                        else
                            cfg_err_reg <= 1'b1;
                    end
                    `CPS_REG_PB_VOL: begin
                        // signed half-dB steps: +48 is +24 dB, -127 is -63.5 dB
                        if ($signed(wd[7:0]) <= $signed(`CPS_PB_VOL_MAX) &&
                            $signed(wd[7:0]) >= $signed(`CPS_PB_VOL_MIN))
                            pb_vol_reg <= wd[7:0];
                        else
                            cfg_err_reg <= 1'b1;
                    end
                    `CPS_REG_COEF_ADDR: coef_addr_reg <= wd[5:0];
                    `CPS_REG_COEF_DATA: coef_addr_reg <= coef_addr_reg + 6'h01;
                    `CPS_REG_STATUS: if (wd[1]) cfg_err_reg <= 1'b0;
                    `CPS_REG_PB_RATE: begin
                        if (wd[7:0] >= `CPS_PB_RATE_MIN && wd[7:0] <= `CPS_PB_RATE_MAX)
                            pb_rate_reg <= wd[7:0];
                        else
                            cfg_err_reg <= 1'b1;
                    end
                    default: cfg_err_reg <= cfg_err_reg;
                endcase
            end
        end
    end
    // ----------------------------------------
    // playback engine, volume, tone, auto mute
    // ----------------------------------------
    wire [15:0] src = ctrl_reg[`CPS_CTRL_BEEP] ? tone_reg : fifo_out_data;
    // coarse gain: shift by whole 6 dB steps of the half-dB setting, saturating
    wire signed [7:0] vol_s = $signed(pb_vol_reg);
    wire [7:0] vol_mag = vol_s[7] ? ((~pb_vol_reg) + 8'h01) : pb_vol_reg;
    wire [7:0] sh_full = vol_mag / 8'h0C;
    wire [3:0] sh = sh_full[3:0];
    wire signed [31:0] up = $signed({{16{src[15]}}, src}) <<< sh;
    wire signed [15:0] dn = $signed(src) >>> sh;
    reg [15:0] gain_out;
    always @* begin
        if (vol_s[7])
            gain_out = dn;
        else if (up > 32'sd32767)
            gain_out = 16'h7FFF;
        else if (up < -32'sd32768)
            gain_out = 16'h8000;
        else
            gain_out = up[15:0];
    end
    wire muted = ctrl_reg[`CPS_CTRL_MUTE] || auto_muted_reg;
    always @(posedge clock) begin
        if (rst) begin
            tone_reg <= 16'h0000;
            quiet_cnt_reg <= 12'h000;
            auto_muted_reg <= 1'b0;
            eng_reg <= 16'h0000;
            eng_valid_reg <= 1'b0;
            pb_sample <= 16'h0000;
            pb_sample_valid <= 1'b0;
        end else if (ce) begin
            eng_valid_reg <= 1'b0;
            pb_sample_valid <= 1'b0;
            if (pb_tick && pb_pwr)
                tone_reg <= tone_reg + {pb_osr_reg, 5'h00};
            if (pb_pop || (pb_tick && pb_pwr && ctrl_reg[`CPS_CTRL_BEEP])) begin
                eng_reg <= muted ? 16'h0000 : gain_out;
                eng_valid_reg <= 1'b1;
                if (src != 16'h0000 || !ctrl_reg[`CPS_CTRL_AUTOMUTE]) begin
                    quiet_cnt_reg <= 12'h000;
                    auto_muted_reg <= 1'b0;
                end else if (quiet_cnt_reg == `CPS_AUTOMUTE_RUN - 12'h001) begin
                    auto_muted_reg <= 1'b1;
                end else begin
                    quiet_cnt_reg <= quiet_cnt_reg + 12'h001;
                end
            end
            // engine stage feeds the interpolation/modulator stage next cycle
            if (eng_valid_reg) begin
                pb_sample <= eng_reg;
                pb_sample_valid <= 1'b1;
            end
        end
    end
endmodule
